// *** rtl/tsrx_regs.svh ***
// Register offsets, field positions, reset values and timing counts for the temperature and tuning registers.
// Assumes an 8-bit register address space reached through the device's register port.
`ifndef TSRX_REGS_SVH
`define TSRX_REGS_SVH
`define TSRX_OFS_TEMP_CTRL 8'h4e
`define TSRX_OFS_TEMP_RESULT 8'h4f
`define TSRX_OFS_LNA_SEL 8'h58
`define TSRX_OFS_AGC_MARGIN 8'h6f
`define TSRX_OFS_LOW_IDX_OFS 8'h71
`define TSRX_BIT_TRIGGER 3
`define TSRX_BIT_IN_PROGRESS 2
`define TSRX_CTRL_LOW_BITS 2'h1
`define TSRX_RST_LNA_SEL 8'h1b
`define TSRX_LNA_NORMAL 8'h1b
`define TSRX_LNA_HIGH 8'h2d
`define TSRX_RST_AGC_MARGIN 8'h30
`define TSRX_AGC_NORMAL 8'h00
`define TSRX_AGC_LOW_IDX 8'h10
`define TSRX_AGC_STD 8'h30
`define TSRX_RST_LOW_IDX_OFS 8'h00
`define TSRX_OFS_STEP_HZ 16'd488
`define TSRX_CONV_TIME_NS 16'd1000
`define TSRX_CLK_PERIOD_NS 16'd10
`define TSRX_CONV_CYCLES (`TSRX_CONV_TIME_NS / `TSRX_CLK_PERIOD_NS)
`endif

// *** rtl/tsrx_pkg.sv ***
// Types shared by the temperature and tuning register block.
// Assumes offsets and counts come from tsrx_regs.svh.
package tsrx_pkg;
	typedef enum logic [1:0] {
		TSRX_IDLE = 2'h0,
		TSRX_CONVERT = 2'h1,
		TSRX_DONE = 2'h3
	} tsrx_conv_state_t;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tsrx_reg_req_t;

	typedef struct packed {
		logic lna_high_gain;
		logic [7:0] digital_gain_tracking_setting;
		logic low_index_freq_correction_enable;
		logic signed [23:0] applied_freq_offset_hz;
		logic rx_blocked;
	} tsrx_tuning_t;
endpackage

// *** rtl/tsrx_converter.sv ***
// Temperature conversion sequencer: one conversion per start pulse, fixed length.
// Assumes a sensor sample input that is already synchronous to clock.
`timescale 1ns/1ps
`include "tsrx_regs.svh"
module tsrx_converter (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [7:0] sensor_sample,
	output logic busy,
	output logic done,
	output logic [7:0] reading
);
	tsrx_pkg::tsrx_conv_state_t state_ff, nxt_state;
	logic [15:0] count_ff, nxt_count;
	logic [7:0] reading_ff, nxt_reading;
	wire logic count_end = (count_ff == (`TSRX_CONV_CYCLES - 16'd1));

	// Next-state and counter decode
	always_comb begin
		nxt_state = state_ff;
		nxt_count = count_ff;
		nxt_reading = reading_ff;
		unique case (state_ff)
			tsrx_pkg::TSRX_IDLE: begin
				nxt_count = 16'h0000;
				if (start) begin
					nxt_state = tsrx_pkg::TSRX_CONVERT;
				end
			end
			tsrx_pkg::TSRX_CONVERT: begin
				nxt_count = count_ff + 16'h0001;
				if (count_end) begin
					nxt_state = tsrx_pkg::TSRX_DONE;
					nxt_reading = sensor_sample;
				end
			end
			tsrx_pkg::TSRX_DONE: begin
				nxt_state = tsrx_pkg::TSRX_IDLE;
			end
			default: begin
				nxt_state = tsrx_pkg::TSRX_IDLE;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= tsrx_pkg::TSRX_IDLE;
			count_ff <= 16'h0000;
			reading_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
			reading_ff <= nxt_reading;
		end
	end

	// Busy through conversion, done for one cycle after
	assign busy = (state_ff == tsrx_pkg::TSRX_CONVERT);
	assign done = (state_ff == tsrx_pkg::TSRX_DONE);
	assign reading = reading_ff;
endmodule

// *** rtl/tsrx_regfile.sv ***
// Temperature sensor control, temperature result and three receiver tuning registers.
// Assumes a synchronous single-cycle register port from the device's serial interface on clock.
// Assumes sensor_sample and the correction enable arrive from outside the clock domain.
`timescale 1ns/1ps
`include "tsrx_regs.svh"
// Overview of operation
// - Writing one to the trigger bit starts a single temperature conversion unless one is running or in its done cycle.
// - The trigger bit always reads back as zero.
// - The in-progress bit reads one for the whole conversion.
// - The in-progress bit clears by itself when the conversion ends.
// - Reception is blocked while a conversion runs and software waits for the flag to clear.
// - The result is an 8-bit read-only reading of minus one degree per count needing offset calibration.
// - The LNA register selects normal at 0x1b, high sensitivity at 0x2d and resets to 0x1b.
// - The AGC register selects normal at 0x00 and improved margin at 0x10 or 0x30.
// - The low-index offset value times 488 Hz is the applied offset and resets to 0x00.
// - The low-index offset applies only while the low-index correction enable is set.
module tsrx_regfile (
	input wire logic clock,
	input wire logic reset_n,
	input tsrx_pkg::tsrx_reg_req_t req,
	input wire logic [7:0] sensor_sample,
	input wire logic low_index_freq_correction_enable,
	output logic [7:0] rdata,
	output tsrx_pkg::tsrx_tuning_t tuning
);
	// Register storage
	logic [7:0] lna_sensitivity_select_ff;
	logic [7:0] agc_fading_margin_ff;
	logic [7:0] low_index_freq_offset_ff;
	logic [7:0] nxt_lna_sel;
	logic [7:0] nxt_agc_margin;
	logic [7:0] nxt_low_idx_ofs;

	// Output stage
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	tsrx_pkg::tsrx_tuning_t tuning_ff;
	tsrx_pkg::tsrx_tuning_t nxt_tuning;

	// Conversion sequencer interface
	logic conv_busy;
	logic conv_done;
	logic [7:0] thermal_reading;

	// Pin synchroniser and filter stages
	logic [7:0] sensor_meta_ff;
	logic [7:0] sensor_sync_ff;
	logic [7:0] sensor_prev_ff;
	logic [7:0] sensor_stable_ff;
	logic [7:0] nxt_sensor_stable;
	logic low_en_meta_ff;
	logic low_en_sync_ff;

	// Sign-extend an 8-bit offset count and scale by the step
	function automatic logic signed [23:0] scale_offset(input logic [7:0] cnt);
		logic signed [23:0] ext;
		ext = {{16{cnt[7]}}, cnt};
		scale_offset = 24'(ext * $signed({8'h00, `TSRX_OFS_STEP_HZ}));
	endfunction

	// Match a request address against one register offset
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
		addr_hit = (addr == offset);
	endfunction

	// Address decode
	wire logic hit_ctrl = addr_hit(req.addr, `TSRX_OFS_TEMP_CTRL);
	wire logic hit_result = addr_hit(req.addr, `TSRX_OFS_TEMP_RESULT);
	wire logic hit_lna = addr_hit(req.addr, `TSRX_OFS_LNA_SEL);
	wire logic hit_agc = addr_hit(req.addr, `TSRX_OFS_AGC_MARGIN);
	wire logic hit_ofs = addr_hit(req.addr, `TSRX_OFS_LOW_IDX_OFS);
	wire logic thermal_conversion_in_progress = conv_busy | conv_done;
	wire logic thermal_conversion_trigger = req.wr_en & hit_ctrl & req.wdata[`TSRX_BIT_TRIGGER];
	wire logic conv_start = thermal_conversion_trigger & ~thermal_conversion_in_progress;

	// Per-register write strobes
	wire logic wr_lna = req.wr_en & hit_lna;
	wire logic wr_agc = req.wr_en & hit_agc;
	wire logic wr_ofs = req.wr_en & hit_ofs;

	// Per-register read strobes
	wire logic rd_ctrl = req.rd_en & hit_ctrl;
	wire logic rd_result = req.rd_en & hit_result;
	wire logic rd_lna = req.rd_en & hit_lna;
	wire logic rd_agc = req.rd_en & hit_agc;
	wire logic rd_ofs = req.rd_en & hit_ofs;

	// Next values of the writable registers
	assign nxt_lna_sel = wr_lna ? req.wdata : lna_sensitivity_select_ff;
	assign nxt_agc_margin = wr_agc ? req.wdata : agc_fading_margin_ff;
	assign nxt_low_idx_ofs = wr_ofs ? req.wdata : low_index_freq_offset_ff;

	// Sensor word is taken only after two equal samples
	wire logic sensor_steady = (sensor_sync_ff == sensor_prev_ff);
	assign nxt_sensor_stable = sensor_steady ? sensor_sync_ff : sensor_stable_ff;

	// Conversion sequencer
	tsrx_converter u_conv (
		.clock(clock),
		.reset_n(reset_n),
		.start(conv_start),
		.sensor_sample(sensor_stable_ff),
		.busy(conv_busy),
		.done(conv_done),
		.reading(thermal_reading)
	);

	// Control register image: trigger reads zero, low bits fixed
	wire logic [7:0] ctrl_image = {4'h0, 1'b0, conv_busy, `TSRX_CTRL_LOW_BITS};

	// Read mux, zero when no register is read
	always_comb begin
		nxt_rdata = 8'h00;
		if (rd_ctrl) begin
			nxt_rdata = ctrl_image;
		end else if (rd_result) begin
			nxt_rdata = thermal_reading;
		end else if (rd_lna) begin
			nxt_rdata = lna_sensitivity_select_ff;
		end else if (rd_agc) begin
			nxt_rdata = agc_fading_margin_ff;
		end else if (rd_ofs) begin
			nxt_rdata = low_index_freq_offset_ff;
		end
	end

	// Tuning values ahead of the output register
	wire logic lna_high_sel = (lna_sensitivity_select_ff == `TSRX_LNA_HIGH);
	wire logic signed [23:0] offset_scaled = scale_offset(low_index_freq_offset_ff);
	wire logic signed [23:0] offset_gated = low_en_sync_ff ? offset_scaled : 24'sh000000;

	// Tuning outputs derived from the registers
	always_comb begin
		nxt_tuning = '0;
		nxt_tuning.lna_high_gain = lna_high_sel;
		nxt_tuning.digital_gain_tracking_setting = agc_fading_margin_ff;
		nxt_tuning.low_index_freq_correction_enable = low_en_sync_ff;
		nxt_tuning.applied_freq_offset_hz = offset_gated;
		nxt_tuning.rx_blocked = conv_busy;
	end

	// Enable pin synchroniser
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			low_en_meta_ff <= 1'b0;
			low_en_sync_ff <= 1'b0;
		end else begin
			low_en_meta_ff <= low_index_freq_correction_enable;
			low_en_sync_ff <= low_en_meta_ff;
		end
	end

	// Sensor word synchroniser
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sensor_meta_ff <= 8'h00;
			sensor_sync_ff <= 8'h00;
		end else begin
			sensor_meta_ff <= sensor_sample;
			sensor_sync_ff <= sensor_meta_ff;
		end
	end

	// Sensor word filter, bits may land a cycle apart
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sensor_prev_ff <= 8'h00;
			sensor_stable_ff <= 8'h00;
		end else begin
			sensor_prev_ff <= sensor_sync_ff;
			sensor_stable_ff <= nxt_sensor_stable;
		end
	end

	// LNA sensitivity register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lna_sensitivity_select_ff <= `TSRX_RST_LNA_SEL;
		end else begin
			lna_sensitivity_select_ff <= nxt_lna_sel;
		end
	end

	// AGC fading margin register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			agc_fading_margin_ff <= `TSRX_RST_AGC_MARGIN;
		end else begin
			agc_fading_margin_ff <= nxt_agc_margin;
		end
	end

	// Low-index offset register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			low_index_freq_offset_ff <= `TSRX_RST_LOW_IDX_OFS;
		end else begin
			low_index_freq_offset_ff <= nxt_low_idx_ofs;
		end
	end

	// Read data register, zero between reads
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Tuning output register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tuning_ff <= '0;
		end else begin
			tuning_ff <= nxt_tuning;
		end
	end

	assign rdata = rdata_ff;
	assign tuning = tuning_ff;
endmodule

// *** sim/tsrx_regfile_sva.sv ***
// Checker for the temperature and tuning register block.
// Assumes it is bound to tsrx_regfile and sees only its ports.
`timescale 1ns/1ps
module tsrx_regfile_sva (
	input wire logic clock,
	input wire logic reset_n,
	input tsrx_pkg::tsrx_reg_req_t req,
	input wire logic [7:0] sensor_sample,
	input wire logic low_index_freq_correction_enable,
	input wire logic [7:0] rdata,
	input tsrx_pkg::tsrx_tuning_t tuning
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Decoded requests
	wire logic rd_ctl = req.rd_en && req.addr == 8'h4e;
	wire logic trig = req.wr_en && req.addr == 8'h4e && req.wdata[3];
	wire logic lna_wr = req.wr_en && req.addr == 8'h58;
	wire logic agc_wr = req.wr_en && req.addr == 8'h6f;
	AST_STATUS_RD: assert property (rd_ctl |=> rdata == {5'h00, tuning.rx_blocked, 2'h1})
		else $error("status read wrong");
	AST_TRIG_START: assert property (trig && !tuning.rx_blocked |=> ##1 tuning.rx_blocked [*8])
		else $error("trigger did not start");
	AST_CONV_LEN: assert property ($rose(tuning.rx_blocked) |-> ##100 $fell(tuning.rx_blocked))
		else $error("conversion length wrong");
	AST_LNA_MODE: assert property (lna_wr |-> ##2 tuning.lna_high_gain == ($past(req.wdata, 2) == 8'h2d))
		else $error("lna mode wrong");
	AST_AGC_MODE: assert property (agc_wr |-> ##2 tuning.digital_gain_tracking_setting == $past(req.wdata, 2))
		else $error("agc setting wrong");
	AST_OFS_GATE: assert property (!tuning.low_index_freq_correction_enable &&
		!$past(tuning.low_index_freq_correction_enable) |-> tuning.applied_freq_offset_hz == 24'sh0)
		else $error("offset applied while off");
	AST_OFS_STEP: assert property (tuning.applied_freq_offset_hz % 488 == 0)
		else $error("offset not a step multiple");
	AST_RD_IDLE: assert property (!req.rd_en |=> rdata == 8'h00)
		else $error("read data without read");
	// Main scenarios
	cover property (trig && !tuning.rx_blocked);
	cover property (trig && tuning.rx_blocked);
	cover property (tuning.lna_high_gain);
endmodule
bind tsrx_regfile tsrx_regfile_sva u_sva (.clock(clock), .reset_n(reset_n), .req(req),
	.sensor_sample(sensor_sample), .low_index_freq_correction_enable(low_index_freq_correction_enable),
	.rdata(rdata), .tuning(tuning));

// *** sim/tsrx_regfile_tb_top.sv ***
// Self-checking bench for the temperature and tuning register block.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
module tsrx_regfile_tb_top;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	tsrx_pkg::tsrx_reg_req_t req = '0;
	logic [7:0] sensor_sample = 8'h00;
	logic low_index_freq_correction_enable = 1'b0;
	logic [7:0] rdata;
	tsrx_pkg::tsrx_tuning_t tuning;
	logic [15:0] seed = 16'h0ea4;
	logic [7:0] d;
	logic [7:0] modes [5] = '{8'h1b, 8'h2d, 8'h00, 8'h10, 8'h30};
	int errors = 0;
	int checks_done = 0;
	int m [int];
	tsrx_regfile dut (.clock(clock), .reset_n(reset_n), .req(req), .sensor_sample(sensor_sample),
		.low_index_freq_correction_enable(low_index_freq_correction_enable), .rdata(rdata), .tuning(tuning));
	// Clock
	always #5 clock = ~clock;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] seen);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Register port cycles, one strobe cycle then one idle cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: v};
		@(negedge clock);
		req.wr_en <= 1'b0;
		@(negedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clock);
		req.rd_en <= 1'b0;
		chk("rdata", {16'h0000, exp}, {16'h0000, rdata});
		@(negedge clock);
	endtask
	// Main sequence
	initial begin
		m = '{8'h4e: 8'h01, 8'h4f: 8'h00, 8'h58: 8'h1b, 8'h6f: 8'h30, 8'h71: 8'h00, 8'h10: 8'h00};
		repeat (4) @(negedge clock);
		reset_n = 1'b1;
		foreach (m[a]) begin
			rd(8'(a), 8'(m[a]));
		end
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			d = (i < 5) ? modes[i] : seed[7:0];
			wr(8'h58, d);
			wr(8'h6f, d);
			repeat (2) @(negedge clock);
			chk("lna", {23'h000000, d == 8'h2d}, {23'h000000, tuning.lna_high_gain});
			chk("agc", {16'h0000, d}, {16'h0000, tuning.digital_gain_tracking_setting});
			rd(8'h58, d);
			rd(8'h6f, d);
		end
		$display("test modes done");
		for (int e = 0; e < 2; e++) begin
			seed = lfsr(seed);
			low_index_freq_correction_enable = (e == 0);
			wr(8'h71, seed[7:0]);
			repeat (6) @(negedge clock);
			chk("offset", (e == 0) ? 24'($signed(seed[7:0]) * 488) : 24'h000000, tuning.applied_freq_offset_hz);
			chk("enable", {23'h000000, e == 0}, {23'h000000, tuning.low_index_freq_correction_enable});
			rd(8'h71, seed[7:0]);
		end
		$display("test offset done");
		for (int n = 0; n < 2; n++) begin
			seed = lfsr(seed);
			sensor_sample = seed[7:0];
			repeat (4) @(negedge clock);
			wr(8'h4e, 8'hff);
			wr(8'h4e, 8'h08);
			wr(8'h4f, 8'h5a);
			rd(8'h4e, 8'h05);
			rd(8'h4f, 8'(m[8'h4f]));
			chk("blocked", 24'h000001, {23'h000000, tuning.rx_blocked});
			d = 8'h00;
			while (tuning.rx_blocked !== 1'b0) begin
				@(negedge clock);
				d++;
				if (d == 8'hc8) begin
					$display("ERROR conversion wait expected 0 seen 1");
					errors++;
					results();
				end
			end
			m[8'h4f] = sensor_sample;
			rd(8'h4e, 8'h01);
			rd(8'h4f, 8'(m[8'h4f]));
			$display("test conversion %0d done", n);
		end
		results();
	end
endmodule
